// ### shared/ccsc_pkg.sv
package ccsc_pkg;
    // APB word addresses
    localparam logic [7:0] CCSC_ADDR_CTRL = 8'h00;
    localparam logic [7:0] CCSC_ADDR_LIMIT = 8'h04;
    localparam logic [7:0] CCSC_ADDR_STATUS = 8'h08;
    localparam logic [7:0] CCSC_ADDR_FAULT = 8'h0c;
    localparam logic [7:0] CCSC_ADDR_CHGPAR = 8'h10;
    // Control register field positions
    localparam int CCSC_CTRL_CFG_LSB = 0;
    localparam int CCSC_CTRL_MINSYS_LSB = 2;
    localparam int CCSC_CTRL_TERM_EN = 5;
    localparam int CCSC_CTRL_SW_OFF = 6;
    localparam int CCSC_CTRL_LOWBAT_SEL = 7;
    localparam int CCSC_CTRL_RECHG_SEL = 8;
    localparam int CCSC_CTRL_HALF_EN = 9;
    // Configuration codes and reset values
    localparam logic [1:0] CCSC_CFG_DISABLE = 2'h0;
    localparam logic [1:0] CCSC_CFG_CHARGE = 2'h1;
    localparam logic [1:0] CCSC_CFG_BOOST = 2'h2;
    localparam logic [2:0] CCSC_MINSYS_RST = 3'h5;   // 3.5 V
    localparam logic [3:0] CCSC_VLIM_RST = 4'h6;
    localparam logic [2:0] CCSC_ILIM_RST = 3'h2;
    localparam logic [5:0] CCSC_ICHG_RST = 6'h20;    // 2.048 A
    localparam logic [3:0] CCSC_IPRE_RST = 4'h3;     // 256 mA
    localparam logic [3:0] CCSC_ITERM_RST = 4'h3;    // 256 mA
    localparam logic [5:0] CCSC_VREG_RST = 6'h2c;    // 4.208 V
    localparam logic [1:0] CCSC_TIMER_RST = 2'h2;    // 8 hours
    localparam logic CCSC_TEMP_PROFILE_RST = 1'b1;   // hot and cold
    // Charge phase codes and boost input-source code
    localparam logic [1:0] CCSC_PH_OFF = 2'h0;
    localparam logic [1:0] CCSC_PH_PRE = 2'h1;
    localparam logic [1:0] CCSC_PH_FAST = 2'h2;
    localparam logic [1:0] CCSC_PH_DONE = 2'h3;
    localparam logic [1:0] CCSC_SRC_BOOST = 2'h3;
    // Current selection at cycle start
    localparam logic [1:0] CCSC_ISEL_TRICKLE = 2'h1; // 100 mA
    localparam logic [1:0] CCSC_ISEL_PRE = 2'h2;
    localparam logic [1:0] CCSC_ISEL_FAST = 2'h3;
    // Timing
    localparam int CCSC_CLK_MHZ = 250;
    localparam int CCSC_BOOST_DLY_MS = 220;
    localparam int CCSC_ALERT_US = 256;
    localparam int CCSC_ALERT_CYC = CCSC_ALERT_US * CCSC_CLK_MHZ;
    localparam int CCSC_MS_CYC = 1000 * CCSC_CLK_MHZ;
    localparam int CCSC_BLINK_MS = 500;

    typedef struct packed {
        logic bat_above_lowbat;
        logic bat_above_2v;
        logic bat_above_3v;
        logic bat_below_rechg;
        logic bat_above_depl;
        logic sys_below_bat;
        logic sys_at_minsys;
        logic in_below_sleep;
        logic in_over_ilim;
        logic in_below_vlim;
        logic ichg_below_term;
        logic thermal_reg;
        logic converter_on;
        logic timer_fault;
    } ccsc_analog_t;

    typedef struct packed {
        logic cold_ok;
        logic hot_start_ok;
        logic hot_cutoff_ok;
    } ccsc_temp_t;
endpackage

// ### core/ccsc_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Three-stage pin synchroniser; output moves only when stages two and three agree.
module ccsc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;

    initial begin
        if (WIDTH < 1) begin
            $error("ccsc_sync WIDTH must be positive");
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync_out[i] <= 1'b0;
                end else if (s2_q[i] == s3_q[i]) begin
                    sync_out[i] <= s3_q[i];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ### core/ccsc_top.sv
// Summary of operation
// - Boost needs request pin high, config 10, then 220 ms delay.
// - Boost also needs battery above low threshold and input below sleep margin.
// - Input-source status reads 11 while boosting.
// - Minimum system target is a 3-bit field, default 3.5 V.
// - Status bit high while rail held at minimum system voltage.
// - Reduce charge current while input current or voltage limit is violated.
// - Input-regulation status bit high during either input regulation.
// - Supplement on when system below battery; off at depletion.
// - Charge configuration resets to 01, charging enabled.
// - Default charge parameters: 4.208 V, 2.048 A, 256 mA, hot/cold, 8 h.
// - Start cycle only with converter on, enabled, no faults, switch not forced off.
// - Terminate on low current above recharge level; recharge below selected threshold.
// - Phase field: 00 off, 01 pre, 10 fast, 11 done.
// - Cycle completion sets phase 11 and raises alert.
// - Each alert is one 256 us pulse.
// - Status pin low charging, released done or disabled, toggles on thermistor fault.
// - Start current: 100 mA below 2 V, pre below 3 V, fast above.
// - Input or thermal regulation suppresses termination, halves timer rate.
// - Start inside low-to-hot window; suspend outside low-to-cutoff until back.
// - Thermistor fault recorded per pin for cold, one shared bit for hot, alerts host, shown on status pin.
// - After completion switch opens, converter keeps running.
// - Termination-enable bit at 0 prevents low-current termination.
`timescale 1ns/1ps
`default_nettype none
module ccsc_top
    import ccsc_pkg::*;
#(
    parameter int MS_CYC = CCSC_MS_CYC,
    parameter int ALERT_CYC = CCSC_ALERT_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic boost_request_pin,
    input wire logic charge_enable_n_pin,
    input wire ccsc_analog_t analog_in,
    input wire ccsc_temp_t temp_sense_first,
    input wire ccsc_temp_t temp_sense_second,
    output logic boost_en,
    output logic battery_switch_on,
    output logic charge_en,
    output logic [1:0] charge_isel,
    output logic half_rate_timer,
    output logic charge_reduce,
    output logic [2:0] minsys_setting,
    output logic [3:0] vlim_setting,
    output logic [2:0] ilim_setting,
    output logic lowbat_sel,
    output logic rechg_sel,
    output logic stat_out,
    output logic stat_oe_n,
    output logic host_alert
);
    typedef enum logic [3:0] {
        CCSC_ST_IDLE = 4'b0001,
        CCSC_ST_CHG = 4'b0010,
        CCSC_ST_SUSP = 4'b0100,
        CCSC_ST_DONE = 4'b1000
    } ccsc_state_t;

    initial begin
        if (MS_CYC < 2 || ALERT_CYC < 2) begin
            $error("ccsc_top timing parameters too small");
        end
    end

    localparam int MSW = $clog2(MS_CYC + 1);
    localparam int AW = $clog2(ALERT_CYC + 1);

    // Pins and comparators all come from outside the clock domain
    localparam int SW = $bits(ccsc_analog_t) + 2 * $bits(ccsc_temp_t) + 2;
    logic [SW-1:0] sync_s;
    ccsc_analog_t an;
    ccsc_temp_t ts1;
    ccsc_temp_t ts2;
    logic boost_pin_s;
    logic ce_n_s;

    ccsc_sync #(.WIDTH(SW)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({analog_in, temp_sense_first, temp_sense_second, boost_request_pin, charge_enable_n_pin}),
        .sync_out(sync_s)
    );
    assign {an, ts1, ts2, boost_pin_s, ce_n_s} = sync_s;

    // Registers
    logic [1:0] cfg_q;
    logic [2:0] minsys_q;
    logic term_en_q;
    logic sw_off_q;
    logic lowbat_q;
    logic rechg_q;
    logic half_en_q;
    logic [3:0] vlim_q;
    logic [2:0] ilim_q;
    logic [2:0] tfault_q;
    ccsc_state_t st_q;
    logic [1:0] phase_q;
    logic supp_q;

    wire wr = psel && penable && pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= CCSC_CFG_CHARGE;
            minsys_q <= CCSC_MINSYS_RST;
            term_en_q <= 1'b1;
            sw_off_q <= 1'b0;
            lowbat_q <= 1'b0;
            rechg_q <= 1'b0;
            half_en_q <= 1'b1;
            vlim_q <= CCSC_VLIM_RST;
            ilim_q <= CCSC_ILIM_RST;
        end else if (wr) begin
            if (paddr == CCSC_ADDR_CTRL) begin
                cfg_q <= pwdata[CCSC_CTRL_CFG_LSB +: 2];
                minsys_q <= pwdata[CCSC_CTRL_MINSYS_LSB +: 3];
                term_en_q <= pwdata[CCSC_CTRL_TERM_EN];
                sw_off_q <= pwdata[CCSC_CTRL_SW_OFF];
                lowbat_q <= pwdata[CCSC_CTRL_LOWBAT_SEL];
                rechg_q <= pwdata[CCSC_CTRL_RECHG_SEL];
                half_en_q <= pwdata[CCSC_CTRL_HALF_EN];
            end else if (paddr == CCSC_ADDR_LIMIT) begin
                ilim_q <= pwdata[2:0];
                vlim_q <= pwdata[6:3];
            end
        end
    end

    // Free-running millisecond tick
    logic [MSW-1:0] msdiv_q;
    logic ms_tick;
    assign ms_tick = (msdiv_q == MSW'(MS_CYC - 1));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            msdiv_q <= '0;
        end else begin
            msdiv_q <= ms_tick ? '0 : msdiv_q + 1'b1;
        end
    end

    // Boost qualification and delay
    logic boost_req;
    logic [7:0] bdly_q;
    assign boost_req = boost_pin_s && (cfg_q == CCSC_CFG_BOOST)
        && an.bat_above_lowbat && an.in_below_sleep;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bdly_q <= '0;
            boost_en <= 1'b0;
        end else if (!boost_req) begin
            bdly_q <= '0;
            boost_en <= 1'b0;
        end else if (ms_tick && bdly_q != 8'(CCSC_BOOST_DLY_MS)) begin
            bdly_q <= bdly_q + 8'h01;
        end else if (bdly_q == 8'(CCSC_BOOST_DLY_MS)) begin
            boost_en <= 1'b1;
        end
    end

    // Charge cycle
    logic chg_enabled;
    logic t_start_ok;
    logic t_run_ok;
    logic t_fault;
    logic regulating;
    logic term_cond;
    logic rechg_cond;
    assign chg_enabled = (cfg_q == CCSC_CFG_CHARGE) && !ce_n_s && !sw_off_q;
    assign t_start_ok = ts1.cold_ok && ts1.hot_start_ok && ts2.cold_ok && ts2.hot_start_ok;
    assign t_run_ok = ts1.cold_ok && ts1.hot_cutoff_ok && ts2.cold_ok && ts2.hot_cutoff_ok;
    assign t_fault = !t_run_ok;
    assign regulating = an.in_over_ilim || an.in_below_vlim || an.thermal_reg;
    // Termination is held off while the current is not really at its setting
    assign term_cond = term_en_q && an.ichg_below_term && !an.bat_below_rechg && !regulating;
    assign rechg_cond = an.bat_below_rechg;

    logic done_ev;
    assign done_ev = (st_q == CCSC_ST_CHG) && term_cond;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= CCSC_ST_IDLE;
        end else if (!chg_enabled) begin
            st_q <= CCSC_ST_IDLE;
        end else begin
            case (st_q)
                CCSC_ST_IDLE: begin
                    if (an.converter_on && !an.timer_fault && t_start_ok) begin
                        st_q <= CCSC_ST_CHG;
                    end
                end
                CCSC_ST_CHG: begin
                    if (an.timer_fault) begin
                        st_q <= CCSC_ST_IDLE;
                    end else if (t_fault) begin
                        st_q <= CCSC_ST_SUSP;
                    end else if (term_cond) begin
                        st_q <= CCSC_ST_DONE;
                    end
                end
                CCSC_ST_SUSP: begin
                    if (t_start_ok) begin
                        st_q <= CCSC_ST_CHG;
                    end
                end
                CCSC_ST_DONE: begin
                    if (rechg_cond && an.converter_on && t_start_ok) begin
                        st_q <= CCSC_ST_CHG;
                    end
                end
                default: st_q <= CCSC_ST_IDLE;
            endcase
        end
    end

    // Phase and current selection from battery voltage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_q <= CCSC_PH_OFF;
            charge_isel <= 2'h0;
        end else begin
            case (st_q)
                CCSC_ST_CHG, CCSC_ST_SUSP: begin
                    if (!an.bat_above_2v) begin
                        phase_q <= CCSC_PH_PRE;
                        charge_isel <= CCSC_ISEL_TRICKLE;
                    end else if (!an.bat_above_3v) begin
                        phase_q <= CCSC_PH_PRE;
                        charge_isel <= CCSC_ISEL_PRE;
                    end else begin
                        phase_q <= CCSC_PH_FAST;
                        charge_isel <= CCSC_ISEL_FAST;
                    end
                end
                CCSC_ST_DONE: begin
                    phase_q <= CCSC_PH_DONE;
                    charge_isel <= 2'h0;
                end
                default: begin
                    phase_q <= CCSC_PH_OFF;
                    charge_isel <= 2'h0;
                end
            endcase
        end
    end

    // Power path: supplement mode and battery switch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            supp_q <= 1'b0;
        end else if (an.sys_below_bat && an.bat_above_depl) begin
            supp_q <= 1'b1;
        end else if (!an.bat_above_depl || !an.sys_below_bat) begin
            supp_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            battery_switch_on <= 1'b0;
            charge_en <= 1'b0;
            half_rate_timer <= 1'b0;
            charge_reduce <= 1'b0;
        end else begin
            // After completion the switch opens unless supplement needs it
            battery_switch_on <= supp_q || boost_en || (st_q == CCSC_ST_CHG);
            charge_en <= (st_q == CCSC_ST_CHG);
            half_rate_timer <= half_en_q && (st_q == CCSC_ST_CHG) && regulating;
            charge_reduce <= an.in_over_ilim || an.in_below_vlim;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            minsys_setting <= CCSC_MINSYS_RST;
            vlim_setting <= CCSC_VLIM_RST;
            ilim_setting <= CCSC_ILIM_RST;
            lowbat_sel <= 1'b0;
            rechg_sel <= 1'b0;
        end else begin
            minsys_setting <= minsys_q;
            vlim_setting <= vlim_q;
            ilim_setting <= ilim_q;
            lowbat_sel <= lowbat_q;
            rechg_sel <= rechg_q;
        end
    end

    // Thermistor fault record; held until the register is read
    logic tf_event;
    assign tf_event = (st_q == CCSC_ST_CHG) && t_fault;
    wire rd_fault = psel && penable && !pwrite && (paddr == CCSC_ADDR_FAULT);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tfault_q <= 3'h0;
        end else if (tf_event) begin
            // Set wins over the read-clear
            tfault_q <= {!ts1.cold_ok, !(ts1.hot_cutoff_ok && ts2.hot_cutoff_ok), !ts2.cold_ok};
        end else if (rd_fault) begin
            tfault_q <= 3'h0;
        end
    end

    // Host alert: fixed-width pulse; events during a pulse are merged into it
    logic [AW-1:0] alert_cnt_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alert_cnt_q <= '0;
            host_alert <= 1'b0;
        end else if (alert_cnt_q != '0) begin
            alert_cnt_q <= alert_cnt_q - 1'b1;
            host_alert <= (alert_cnt_q != AW'(1));
        end else if (done_ev || tf_event) begin
            alert_cnt_q <= AW'(ALERT_CYC);
            host_alert <= 1'b1;
        end
    end

    // Status pin, open drain: oe_n low pulls the line low
    logic [8:0] blink_ms_q;
    logic blink_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blink_ms_q <= '0;
            blink_q <= 1'b0;
            stat_oe_n <= 1'b1;
            stat_out <= 1'b0;
        end else begin
            stat_out <= 1'b0;
            if (ms_tick) begin
                if (blink_ms_q == 9'(CCSC_BLINK_MS - 1)) begin
                    blink_ms_q <= '0;
                    blink_q <= !blink_q;
                end else begin
                    blink_ms_q <= blink_ms_q + 9'h001;
                end
            end
            if (st_q == CCSC_ST_SUSP) begin
                stat_oe_n <= blink_q;
            end else begin
                stat_oe_n <= (st_q != CCSC_ST_CHG);
            end
        end
    end

    // APB read path, zero wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= 32'h0;
            if (psel && !penable) begin
                if (paddr == CCSC_ADDR_CTRL) begin
                    prdata <= {22'h0, half_en_q, rechg_q, lowbat_q, sw_off_q, term_en_q, minsys_q, cfg_q};
                end else if (paddr == CCSC_ADDR_LIMIT) begin
                    prdata <= {25'h0, vlim_q, ilim_q};
                end else if (paddr == CCSC_ADDR_STATUS) begin
                    prdata <= {24'h0,
                        boost_en ? CCSC_SRC_BOOST : 2'h0,
                        phase_q,
                        an.in_over_ilim || an.in_below_vlim,
                        supp_q,
                        an.thermal_reg,
                        an.sys_at_minsys};
                end else if (paddr == CCSC_ADDR_FAULT) begin
                    prdata <= {29'h0, tfault_q};
                end else if (paddr == CCSC_ADDR_CHGPAR) begin
                    prdata <= {9'h0, CCSC_TEMP_PROFILE_RST, CCSC_TIMER_RST, CCSC_ITERM_RST,
                        CCSC_IPRE_RST, CCSC_ICHG_RST, CCSC_VREG_RST};
                end else begin
                    pslverr <= 1'b1;
                end
            end
        end
    end

    // Assertions
    property p_alert_width;
        @(posedge pclk) disable iff (!presetn)
            $rose(host_alert) |-> host_alert [*8];
    endproperty
    a_alert_width: assert property (p_alert_width) else $error("alert pulse too short");

    property p_boost_needs_req;
        @(posedge pclk) disable iff (!presetn)
            boost_en |-> $past(boost_req);
    endproperty
    a_boost_needs_req: assert property (p_boost_needs_req) else $error("boost without request");

    property p_boost_delay;
        @(posedge pclk) disable iff (!presetn)
            $rose(boost_en) |-> bdly_q == 8'(CCSC_BOOST_DLY_MS);
    endproperty
    a_boost_delay: assert property (p_boost_delay) else $error("boost before delay");

    property p_done_alert;
        @(posedge pclk) disable iff (!presetn)
            (done_ev && alert_cnt_q == '0) |=> host_alert;
    endproperty
    a_done_alert: assert property (p_done_alert) else $error("no alert at completion");

    property p_disable_phase;
        @(posedge pclk) disable iff (!presetn)
            !chg_enabled |=> ##1 phase_q == CCSC_PH_OFF;
    endproperty
    a_disable_phase: assert property (p_disable_phase) else $error("phase not cleared");

    property p_stat_low_charging;
        @(posedge pclk) disable iff (!presetn)
            (st_q == CCSC_ST_CHG) |=> !stat_oe_n;
    endproperty
    a_stat_low_charging: assert property (p_stat_low_charging) else $error("status not low");

    property p_no_term_disabled;
        @(posedge pclk) disable iff (!presetn)
            (st_q == CCSC_ST_CHG && !term_en_q && !t_fault && !an.timer_fault && chg_enabled)
            |=> st_q == CCSC_ST_CHG;
    endproperty
    a_no_term_disabled: assert property (p_no_term_disabled) else $error("terminated while disabled");

    property p_suspend;
        @(posedge pclk) disable iff (!presetn)
            (st_q == CCSC_ST_CHG && t_fault && chg_enabled && !an.timer_fault) |=> st_q == CCSC_ST_SUSP;
    endproperty
    a_suspend: assert property (p_suspend) else $error("no suspend on temp fault");

    property p_reduce;
        @(posedge pclk) disable iff (!presetn)
            (an.in_over_ilim || an.in_below_vlim) |=> charge_reduce;
    endproperty
    a_reduce: assert property (p_reduce) else $error("no current reduction");

    // Completion is seen first in the state, one cycle later in the phase field
    sequence s_cycle_done;
        done_ev && chg_enabled && !an.timer_fault && !t_fault;
    endsequence
    sequence s_done_shown;
        (st_q == CCSC_ST_DONE) ##1 (phase_q == CCSC_PH_DONE);
    endsequence
    property p_done_phase;
        @(posedge pclk) disable iff (!presetn)
            s_cycle_done |=> s_done_shown;
    endproperty
    a_done_phase: assert property (p_done_phase) else $error("phase not done after completion");
endmodule
`default_nettype wire

// ### tb/ccsc_plant.sv
`timescale 1ns/1ps
`default_nettype none
module ccsc_plant
    import ccsc_pkg::*;
(
    input var int vbat_mv,
    input wire logic ovl,
    output var ccsc_analog_t a
);
    // A full cell stops taking current at 4.2 V; overload pulls the rail below the cell
    always_comb begin
        a = '0;
        a.bat_above_lowbat = vbat_mv > 3000;
        a.bat_above_2v = vbat_mv > 2000;
        a.bat_above_3v = vbat_mv > 3000;
        a.bat_below_rechg = vbat_mv < 4100;
        a.bat_above_depl = vbat_mv > 2800;
        a.sys_below_bat = ovl;
        a.sys_at_minsys = vbat_mv < 3500;
        a.in_over_ilim = ovl;
        a.in_below_sleep = 1'b1;
        a.ichg_below_term = vbat_mv >= 4200;
        a.converter_on = 1'b1;
    end
endmodule
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ccsc_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, bpin = 0, cen_n = 0, ovl = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd, seed = 32'h87bc0839;
    logic pready, pslverr, serr, boost_en, sw_on, half, reduce, stat_oe_n, alert, ce, so, lowbat, rechg;
    logic [1:0] isel;
    logic [2:0] ilim, minsys;
    logic [3:0] vlim;
    ccsc_analog_t an;
    ccsc_temp_t ts1 = 3'b111, ts2 = 3'b111;
    int vbat = 3600, miscompares = 0, checks_done = 0, n;
    int vtab[3] = '{1500, 2500, 3600};
    int itab[3] = '{1, 2, 3};
    int ptab[3] = '{1, 1, 2};
    always #2 pclk = ~pclk;
    ccsc_top #(.MS_CYC(20), .ALERT_CYC(16)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .boost_request_pin(bpin), .charge_enable_n_pin(cen_n),
        .analog_in(an), .temp_sense_first(ts1), .temp_sense_second(ts2), .boost_en(boost_en),
        .battery_switch_on(sw_on), .charge_en(ce), .charge_isel(isel), .half_rate_timer(half),
        .charge_reduce(reduce), .minsys_setting(minsys), .vlim_setting(vlim), .ilim_setting(ilim),
        .lowbat_sel(lowbat), .rechg_sel(rechg), .stat_out(so), .stat_oe_n(stat_oe_n), .host_alert(alert));
    ccsc_plant PLANT (.vbat_mv(vbat), .ovl(ovl), .a(an));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wt(input int c);
        repeat (c) @(posedge pclk);
    endtask
    // Length of the next alert pulse in cycles, 0 if none shows within 60
    task automatic alert_len();
        n = 0;
        while (alert !== 1'b1 && n < 60) begin
            @(posedge pclk);
            n++;
        end
        n = 0;
        while (alert === 1'b1 && n < 100) begin
            @(posedge pclk);
            n++;
        end
    endtask
    task automatic test_done();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        wt(20);
        presetn <= 1'b1;
        apb(0, CCSC_ADDR_CTRL, 0);
        chk(rd, 32'h235);
        chk({minsys, lowbat, rechg}, 5'h14);
        apb(0, CCSC_ADDR_CHGPAR, 0);
        chk(rd, 32'h0063382c);
        apb(0, 8'h40, 0);
        chk({rd[30:0], serr}, 32'h1);
        repeat (4) begin
            seed = xs(seed);
            apb(1, CCSC_ADDR_LIMIT, {25'h0, seed[6:0]});
            apb(0, CCSC_ADDR_LIMIT, 0);
            chk(rd, {25'h0, seed[6:0]});
            chk({vlim, ilim}, seed[6:0]);
        end
        for (int i = 0; i < 3; i++) begin
            vbat <= vtab[i];
            // Disable by field, by pin, then by switch force-off
            if (i == 1) begin
                cen_n <= 1'b1;
            end else begin
                apb(1, CCSC_ADDR_CTRL, (i == 0) ? 32'h234 : 32'h275);
            end
            wt(12);
            apb(0, CCSC_ADDR_STATUS, 0);
            chk(rd[5:4], CCSC_PH_OFF);
            chk({so, ce, stat_oe_n}, 3'b001);
            cen_n <= 1'b0;
            apb(1, CCSC_ADDR_CTRL, 32'h235);
            wt(12);
            apb(0, CCSC_ADDR_STATUS, 0);
            chk(rd[5:4], ptab[i]);
            chk(rd[0], vtab[i] < 3500);
            chk(isel, itab[i]);
            chk({so, ce, stat_oe_n}, 3'b010);
        end
        ovl <= 1'b1;
        wt(12);
        apb(0, CCSC_ADDR_STATUS, 0);
        chk(rd[3:2], 2'b11);
        chk({reduce, sw_on, half}, 3'b111);
        ovl <= 1'b0;
        wt(12);
        chk(reduce, 0);
        apb(1, CCSC_ADDR_CTRL, 32'h395);
        vbat <= 4250;
        wt(30);
        apb(0, CCSC_ADDR_STATUS, 0);
        chk(rd[5:4], CCSC_PH_FAST);
        chk({minsys, lowbat, rechg}, 5'h17);
        apb(1, CCSC_ADDR_CTRL, 32'h235);
        alert_len();
        chk(n, 16);
        apb(0, CCSC_ADDR_STATUS, 0);
        chk(rd[5:4], CCSC_PH_DONE);
        chk({sw_on, stat_oe_n}, 2'b01);
        vbat <= 4000;
        wt(12);
        apb(0, CCSC_ADDR_STATUS, 0);
        chk(rd[5:4], CCSC_PH_FAST);
        ts1.hot_cutoff_ok <= 1'b0;
        alert_len();
        chk(n, 16);
        apb(0, CCSC_ADDR_FAULT, 0);
        chk(rd[2:0], 3'b010);
        ts1.hot_cutoff_ok <= 1'b1;
        apb(1, CCSC_ADDR_CTRL, 32'h236);
        bpin <= 1'b1;
        wt(4000);
        chk(boost_en, 0);
        n = 0;
        while (boost_en !== 1'b1 && n < 1000) begin
            @(posedge pclk);
            n++;
        end
        chk(boost_en, 1);
        apb(0, CCSC_ADDR_STATUS, 0);
        chk(rd[7:6], CCSC_SRC_BOOST);
        test_done();
    end
    initial begin
        wt(20000);
        miscompares++;
        test_done();
    end
endmodule
`default_nettype wire
